// ===== core/serial_ctrl_misc_status_regs.sv
// one channel's control, enable and status register bank
// =======================================================
// Overview of operation
// - misc control top three bits issue clock recovery commands, null to nrzi.
// - misc control low bits: loopback, echo, ready source, rate clock, rate enable.
// - enable register bits 7..3 enable break, underrun, cts, sync, carrier interrupts.
// - enable register bit 1 enables the rate generator zero count interrupt.
// - bit 0 opens the extended feature register, bit 2 enables frame fifo.
// - fifteen read registers per channel plus receive data buffer as sixteenth.
// - two read registers give back the written time constant bytes.
// - vector reads raw on first channel, status modified on second.
// - pending register on first channel holds the pending bits, zero otherwise.
// - frame count reads show fifo contents only while fifo is enabled.
// - feature bit 6 makes four config write registers readable.
// - status lives in five registers: status, special, misc, interrupt status, enable readback.
`timescale 1ns/1ps
module serial_ctrl_misc_status_regs (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic IS_CHANNEL_B,
  input wire logic BREAK_ABORT,
  input wire logic TX_UNDERRUN,
  input wire logic CTS,
  input wire logic SYNC_HUNT,
  input wire logic DCD,
  input wire logic TX_EMPTY,
  input wire logic ZERO_COUNT,
  input wire logic RX_AVAIL,
  input wire logic END_OF_FRAME,
  input wire logic CRC_ERROR,
  input wire logic RX_OVERRUN,
  input wire logic PARITY_ERROR,
  input wire logic [2:0] RESIDUE,
  input wire logic ALL_SENT,
  input wire logic [7:0] RX_DATA,
  input wire logic [7:0] MISC_STATUS,
  input wire logic [5:0] PENDING_IN,
  input wire logic [2:0] VECTOR_STATUS,
  input wire logic FRAME_DONE,
  input wire logic [13:0] FRAME_BYTE_COUNT,
  input wire logic RECOVERY_LOCKED,
  input wire logic MISSING_CLOCK_SEEN,
  output logic IRQ,
  output logic RX_DATA_TAKEN,
  output logic LOCAL_LOOPBACK,
  output logic AUTO_ECHO,
  output logic DTR_SOURCE_BAUD_RATE_GENERATOR,
  output logic BAUD_RATE_GENERATOR_SOURCE,
  output logic BAUD_RATE_GENERATOR_ENABLE,
  output logic [15:0] TIME_CONSTANT,
  output logic RECOVERY_SOURCE_PIN,
  output logic RECOVERY_FM,
  output logic [1:0] RECOVERY_STATE,
  output logic MISSING_CLOCK,
  output logic FIFO_ENABLE,
  output logic FEATURE_ACCESS,
  output logic [7:0] SYNC_PATTERN
);
  logic [7:0] misc_ctrl_reg;
  logic [7:0] ext_en_reg;
  logic [7:0] feature_reg;
  logic [7:0] vector_reg;
  logic [7:0] rx_param_reg;
  logic [7:0] misc_mode_reg;
  logic [7:0] tx_param_reg;
  logic [7:0] sync_misc_reg;
  logic [7:0] tc_low_reg;
  logic [7:0] tc_high_reg;
  logic [7:0] sync_reg;
  logic [7:0] tx_rx_status_reg;
  logic [7:0] tx_rx_status_next;
  logic [7:0] special_rx_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] irq_status;
  logic [7:0] irq_set;
  logic [7:0] irq_clear;
  logic rec_src_pin_reg;
  logic rec_fm_reg;
  logic missing_clock;
  logic missing_clear;
  logic [13:0] fifo_head;
  logic fifo_empty;
  logic fifo_pop;
  logic ctrl_wr;
  logic rd_hit;
  logic readback_on;
  serial_regs_pkg::recovery_state_t rec_state_reg;
  serial_regs_pkg::recovery_cmd_t cmd;

  // =======================================================
  // write decode
  assign ctrl_wr = WR && (ADDR == serial_regs_pkg::A_MISC_CTRL);
  assign cmd = serial_regs_pkg::recovery_cmd_t'(WDATA[7:serial_regs_pkg::MC_CMD_LSB]);
  assign readback_on = feature_reg[serial_regs_pkg::EF_READBACK];

  // misc control register, command field is not stored
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      misc_ctrl_reg <= serial_regs_pkg::MISC_CTRL_RST;
    else if (ctrl_wr)
      misc_ctrl_reg <= {3'h0, WDATA[4:0]};
  end

  // enable register and extended feature / sync sharing one address
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      ext_en_reg <= serial_regs_pkg::EXT_ENABLE_RST;
      feature_reg <= serial_regs_pkg::CFG_RST;
      sync_reg <= serial_regs_pkg::CFG_RST;
    end
    else if (WR)
    begin
      if (ADDR == serial_regs_pkg::A_EXT_ENABLE)
        ext_en_reg <= WDATA;
      if (ADDR == serial_regs_pkg::A_FEATURE && ext_en_reg[serial_regs_pkg::EE_FEATURE])
        feature_reg <= WDATA;
      if (ADDR == serial_regs_pkg::A_FEATURE && !ext_en_reg[serial_regs_pkg::EE_FEATURE])
        sync_reg <= WDATA;
    end
  end

  // plain configuration registers kept for readback
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      vector_reg <= serial_regs_pkg::CFG_RST;
      rx_param_reg <= serial_regs_pkg::CFG_RST;
      misc_mode_reg <= serial_regs_pkg::CFG_RST;
      tx_param_reg <= serial_regs_pkg::CFG_RST;
      sync_misc_reg <= serial_regs_pkg::CFG_RST;
      tc_low_reg <= serial_regs_pkg::CFG_RST;
      tc_high_reg <= serial_regs_pkg::CFG_RST;
    end
    else if (WR)
    begin
      unique case (ADDR)
        serial_regs_pkg::A_VECTOR: vector_reg <= WDATA;
        serial_regs_pkg::A_RX_PARAM: rx_param_reg <= WDATA;
        serial_regs_pkg::A_MISC_MODE: misc_mode_reg <= WDATA;
        serial_regs_pkg::A_TX_PARAM: tx_param_reg <= WDATA;
        serial_regs_pkg::A_SYNC_MISC: sync_misc_reg <= WDATA;
        serial_regs_pkg::A_TC_LOW: tc_low_reg <= WDATA;
        serial_regs_pkg::A_TC_HIGH: tc_high_reg <= WDATA;
        default: ;
      endcase
    end
  end

  // =======================================================
  // clock recovery commands
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      rec_state_reg <= serial_regs_pkg::REC_DISABLED;
      rec_src_pin_reg <= 1'b0;
      rec_fm_reg <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      unique case (cmd)
        serial_regs_pkg::CMD_NULL: ;
        serial_regs_pkg::CMD_ENTER_SEARCH: rec_state_reg <= serial_regs_pkg::REC_SEARCH;
        serial_regs_pkg::CMD_CLEAR_MISSING: ;
        serial_regs_pkg::CMD_DISABLE: rec_state_reg <= serial_regs_pkg::REC_DISABLED;
        serial_regs_pkg::CMD_SRC_BAUD_RATE_GENERATOR: rec_src_pin_reg <= 1'b0;
        serial_regs_pkg::CMD_SRC_PIN: rec_src_pin_reg <= 1'b1;
        serial_regs_pkg::CMD_SET_FM: rec_fm_reg <= 1'b1;
        serial_regs_pkg::CMD_SET_NRZI: rec_fm_reg <= 1'b0;
      endcase
    end
    else if (rec_state_reg == serial_regs_pkg::REC_SEARCH && RECOVERY_LOCKED)
      rec_state_reg <= serial_regs_pkg::REC_LOCKED;
  end

  // missing clock flag, cleared by command, a new miss wins
  assign missing_clear = ctrl_wr && (cmd == serial_regs_pkg::CMD_CLEAR_MISSING);
  sticky_bits #(
    .W(1)
  ) u_missing (
    .clk(CLK),
    .reset_n(RESET_N),
    .set_in(MISSING_CLOCK_SEEN),
    .clear_in(missing_clear),
    .bits(missing_clock)
  );

  // =======================================================
  // status registers sampled from the channel
  assign tx_rx_status_next = {BREAK_ABORT, TX_UNDERRUN, CTS, SYNC_HUNT,
                              DCD, TX_EMPTY, ZERO_COUNT, RX_AVAIL};
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      tx_rx_status_reg <= serial_regs_pkg::TX_RX_STATUS_RST;
      special_rx_reg <= serial_regs_pkg::SPECIAL_RX_RST;
    end
    else
    begin
      tx_rx_status_reg <= tx_rx_status_next;
      special_rx_reg <= {END_OF_FRAME, CRC_ERROR, RX_OVERRUN, PARITY_ERROR,
                         RESIDUE, ALL_SENT};
    end
  end

  // =======================================================
  // interrupt events: status line changes and zero count rising
  always_comb
  begin
    irq_set = (tx_rx_status_next ^ tx_rx_status_reg) & serial_regs_pkg::IRQ_EVENT_MASK;
    irq_set[serial_regs_pkg::EE_ZERO] = ZERO_COUNT
      && !tx_rx_status_reg[serial_regs_pkg::EE_ZERO];
  end
  assign irq_clear = (WR && ADDR == serial_regs_pkg::A_IRQ_STATUS) ? WDATA : 8'h00;
  sticky_bits #(
    .W(8)
  ) u_irq_status (
    .clk(CLK),
    .reset_n(RESET_N),
    .set_in(irq_set),
    .clear_in(irq_clear),
    .bits(irq_status)
  );
  // one level interrupt gated by the per-source enables
  assign IRQ = |(irq_status & ext_en_reg & serial_regs_pkg::IRQ_EVENT_MASK);

  // =======================================================
  // frame byte count fifo
  assign fifo_pop = RD && (ADDR == serial_regs_pkg::R_FRAME_HIGH)
    && ext_en_reg[serial_regs_pkg::EE_FIFO_EN];
  frame_count_fifo #(
    .W(serial_regs_pkg::FRAME_COUNT_W),
    .DEPTH(serial_regs_pkg::FRAME_FIFO_DEPTH)
  ) u_frame_fifo (
    .clk(CLK),
    .reset_n(RESET_N),
    .push(FRAME_DONE && ext_en_reg[serial_regs_pkg::EE_FIFO_EN]),
    .push_data(FRAME_BYTE_COUNT),
    .pop(fifo_pop),
    .head(fifo_head),
    .empty(fifo_empty),
    .full()
  );

  // =======================================================
  // read multiplexer
  always_comb
  begin
    rdata_next = 8'h00;
    rd_hit = 1'b0;
    if (RD)
    begin
      unique case (ADDR)
        serial_regs_pkg::R_TX_RX_STATUS: rdata_next = tx_rx_status_reg;
        serial_regs_pkg::R_SPECIAL_RX: rdata_next = special_rx_reg;
        serial_regs_pkg::R_VECTOR:
          rdata_next = IS_CHANNEL_B ? {vector_reg[7:4], VECTOR_STATUS, vector_reg[0]}
                                    : vector_reg;
        serial_regs_pkg::R_PENDING:
          rdata_next = IS_CHANNEL_B ? 8'h00 : {2'h0, PENDING_IN};
        serial_regs_pkg::R_MISC_MODE_RB: rdata_next = readback_on ? misc_mode_reg : 8'h00;
        serial_regs_pkg::R_TX_PARAM_RB: rdata_next = readback_on ? tx_param_reg : 8'h00;
        serial_regs_pkg::R_FRAME_LOW:
          rdata_next = ext_en_reg[serial_regs_pkg::EE_FIFO_EN] ? fifo_head[7:0] : 8'h00;
        serial_regs_pkg::R_FRAME_HIGH:
          rdata_next = ext_en_reg[serial_regs_pkg::EE_FIFO_EN]
                       ? {!fifo_empty, 1'b0, fifo_head[13:8]} : 8'h00;
        serial_regs_pkg::R_RX_DATA:
        begin
          rdata_next = RX_DATA;
          rd_hit = 1'b1;
        end
        serial_regs_pkg::R_RX_PARAM_RB: rdata_next = readback_on ? rx_param_reg : 8'h00;
        serial_regs_pkg::R_MISC_STATUS: rdata_next = MISC_STATUS;
        serial_regs_pkg::R_IRQ_STATUS: rdata_next = irq_status;
        serial_regs_pkg::R_TC_LOW: rdata_next = tc_low_reg;
        serial_regs_pkg::R_TC_HIGH: rdata_next = tc_high_reg;
        serial_regs_pkg::R_SYNC_MISC_RB:
          rdata_next = readback_on ? sync_misc_reg : 8'h00;
        serial_regs_pkg::R_ENABLE_RB: rdata_next = ext_en_reg;
      endcase
    end
  end

  // read data stand one cycle after the strobe only
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // =======================================================
  // outputs
  assign RDATA = rdata_reg;
  assign RX_DATA_TAKEN = rd_hit;
  assign LOCAL_LOOPBACK = misc_ctrl_reg[serial_regs_pkg::MC_LOOPBACK];
  assign AUTO_ECHO = misc_ctrl_reg[serial_regs_pkg::MC_ECHO];
  assign DTR_SOURCE_BAUD_RATE_GENERATOR = misc_ctrl_reg[serial_regs_pkg::MC_DTR_SRC];
  assign BAUD_RATE_GENERATOR_SOURCE = misc_ctrl_reg[serial_regs_pkg::MC_BAUD_RATE_GENERATOR_SRC];
  assign BAUD_RATE_GENERATOR_ENABLE = misc_ctrl_reg[serial_regs_pkg::MC_BAUD_RATE_GENERATOR_EN];
  assign TIME_CONSTANT = {tc_high_reg, tc_low_reg};
  assign RECOVERY_SOURCE_PIN = rec_src_pin_reg;
  assign RECOVERY_FM = rec_fm_reg;
  assign RECOVERY_STATE = rec_state_reg;
  assign MISSING_CLOCK = missing_clock;
  assign FIFO_ENABLE = ext_en_reg[serial_regs_pkg::EE_FIFO_EN];
  assign FEATURE_ACCESS = ext_en_reg[serial_regs_pkg::EE_FEATURE];
  assign SYNC_PATTERN = sync_reg;

  // =======================================================
  // assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_cmd(logic [2:0] c);
    ctrl_wr && WDATA[7:5] == c;
  endsequence
  property p_cmd_search;
    s_cmd(3'h1) |=> RECOVERY_STATE == 2'h1;
  endproperty
  a_cmd_search: assert property (p_cmd_search) else $error("search command ignored");
  property p_cmd_disable;
    s_cmd(3'h3) |=> RECOVERY_STATE == 2'h0
      ##1 RECOVERY_STATE == 2'h0 || $past(ctrl_wr && WDATA[7:5] == 3'h1);
  endproperty
  a_cmd_disable: assert property (p_cmd_disable) else $error("disable command ignored");
  property p_ctrl_bits;
    ctrl_wr |=> LOCAL_LOOPBACK == $past(WDATA[4]) && AUTO_ECHO == $past(WDATA[3])
      && BAUD_RATE_GENERATOR_ENABLE == $past(WDATA[0]);
  endproperty
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("control bits wrong");
  property p_cts_irq;
    (CTS != tx_rx_status_reg[5]) && ext_en_reg[5] && !WR |=> IRQ;
  endproperty
  a_cts_irq: assert property (p_cts_irq) else $error("cts change gave no irq");
  property p_zero_irq;
    ZERO_COUNT && !tx_rx_status_reg[1] && ext_en_reg[1] && !WR |=> IRQ && irq_status[1];
  endproperty
  a_zero_irq: assert property (p_zero_irq) else $error("zero count gave no irq");
  property p_feature;
    WR && ADDR == 4'h7 && ext_en_reg[0] |=> feature_reg == $past(WDATA);
  endproperty
  a_feature: assert property (p_feature) else $error("feature write lost");
  property p_rx_read;
    RD && ADDR == 4'h8 |-> RX_DATA_TAKEN ##1 RDATA == $past(RX_DATA) ##1 RDATA == 8'h00 || $past(RD);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive buffer read wrong");
  property p_tc_read;
    WR && ADDR == 4'hD ##1 RD && ADDR == 4'hD |=> RDATA == $past(WDATA, 2);
  endproperty
  a_tc_read: assert property (p_tc_read) else $error("time constant readback wrong");
  property p_vector_b;
    RD && ADDR == 4'h2 && IS_CHANNEL_B |=> RDATA[3:1] == $past(VECTOR_STATUS);
  endproperty
  a_vector_b: assert property (p_vector_b) else $error("vector status missing");
  property p_pending;
    RD && ADDR == 4'h3 |=> RDATA == ($past(IS_CHANNEL_B) ? 8'h00 : {2'h0, $past(PENDING_IN)});
  endproperty
  a_pending: assert property (p_pending) else $error("pending bits wrong");
  property p_frame_gate;
    RD && ADDR[3:1] == 3'h3 && !ext_en_reg[2] |=> RDATA == 8'h00;
  endproperty
  a_frame_gate: assert property (p_frame_gate) else $error("frame count read while off");
  property p_readback;
    RD && ADDR == 4'h9 && feature_reg[6] |=> RDATA == $past(rx_param_reg);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");
  property p_status_read;
    RD && ADDR == 4'h0 |=> RDATA == $past(tx_rx_status_next, 2);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  property p_special;
    RD && ADDR == 4'h1 |=> RDATA[3:1] == $past(RESIDUE, 2) && RDATA[7] == $past(END_OF_FRAME, 2);
  endproperty
  a_special: assert property (p_special) else $error("special receive read wrong");
endmodule : serial_ctrl_misc_status_regs

// ===== core/serial_regs_pkg.sv
// constants and types for the serial channel control and status register bank
package serial_regs_pkg;
  // =======================================================
  // write addresses
  localparam logic [3:0] A_VECTOR = 4'h2;
  localparam logic [3:0] A_RX_PARAM = 4'h3;
  localparam logic [3:0] A_MISC_MODE = 4'h4;
  localparam logic [3:0] A_TX_PARAM = 4'h5;
  localparam logic [3:0] A_FEATURE = 4'h7;
  localparam logic [3:0] A_SYNC_MISC = 4'hA;
  localparam logic [3:0] A_IRQ_STATUS = 4'hB;
  localparam logic [3:0] A_TC_LOW = 4'hC;
  localparam logic [3:0] A_TC_HIGH = 4'hD;
  localparam logic [3:0] A_MISC_CTRL = 4'hE;
  localparam logic [3:0] A_EXT_ENABLE = 4'hF;
  // =======================================================
  // read addresses
  localparam logic [3:0] R_TX_RX_STATUS = 4'h0;
  localparam logic [3:0] R_SPECIAL_RX = 4'h1;
  localparam logic [3:0] R_VECTOR = 4'h2;
  localparam logic [3:0] R_PENDING = 4'h3;
  localparam logic [3:0] R_MISC_MODE_RB = 4'h4;
  localparam logic [3:0] R_TX_PARAM_RB = 4'h5;
  localparam logic [3:0] R_FRAME_LOW = 4'h6;
  localparam logic [3:0] R_FRAME_HIGH = 4'h7;
  localparam logic [3:0] R_RX_DATA = 4'h8;
  localparam logic [3:0] R_RX_PARAM_RB = 4'h9;
  localparam logic [3:0] R_MISC_STATUS = 4'hA;
  localparam logic [3:0] R_IRQ_STATUS = 4'hB;
  localparam logic [3:0] R_TC_LOW = 4'hC;
  localparam logic [3:0] R_TC_HIGH = 4'hD;
  localparam logic [3:0] R_SYNC_MISC_RB = 4'hE;
  localparam logic [3:0] R_ENABLE_RB = 4'hF;
  // =======================================================
  // field positions
  localparam int MC_CMD_LSB = 5;
  localparam int MC_LOOPBACK = 4;
  localparam int MC_ECHO = 3;
  localparam int MC_DTR_SRC = 2;
  localparam int MC_BAUD_RATE_GENERATOR_SRC = 1;
  localparam int MC_BAUD_RATE_GENERATOR_EN = 0;
  localparam int EE_BREAK = 7;
  localparam int EE_UNDERRUN = 6;
  localparam int EE_CTS = 5;
  localparam int EE_SYNC = 4;
  localparam int EE_DCD = 3;
  localparam int EE_FIFO_EN = 2;
  localparam int EE_ZERO = 1;
  localparam int EE_FEATURE = 0;
  localparam int EF_READBACK = 6;
  // =======================================================
  // reset values and masks
  localparam logic [7:0] EXT_ENABLE_RST = 8'hF0;
  localparam logic [7:0] MISC_CTRL_RST = 8'h00;
  localparam logic [7:0] TX_RX_STATUS_RST = 8'h44;
  localparam logic [7:0] SPECIAL_RX_RST = 8'h06;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] IRQ_EVENT_MASK = 8'hFA;
  localparam int FRAME_FIFO_DEPTH = 4;
  localparam int FRAME_COUNT_W = 14;
  // =======================================================
  // types
  typedef enum logic [2:0] {
    CMD_NULL = 3'b000,
    CMD_ENTER_SEARCH = 3'b001,
    CMD_CLEAR_MISSING = 3'b010,
    CMD_DISABLE = 3'b011,
    CMD_SRC_BAUD_RATE_GENERATOR = 3'b100,
    CMD_SRC_PIN = 3'b101,
    CMD_SET_FM = 3'b110,
    CMD_SET_NRZI = 3'b111
  } recovery_cmd_t;
  typedef enum logic [1:0] {
    REC_DISABLED = 2'b00,
    REC_SEARCH = 2'b01,
    REC_LOCKED = 2'b10
  } recovery_state_t;
endpackage : serial_regs_pkg

// ===== core/sticky_bits.sv
// sticky flag bits, set by hardware and cleared by request, set wins
`timescale 1ns/1ps
module sticky_bits #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clear_in,
  output logic [W-1:0] bits
);
  // =======================================================
  // flag storage
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      bits <= '0;
    else
      bits <= (bits & ~clear_in) | set_in;
  end
endmodule : sticky_bits

// ===== core/frame_count_fifo.sv
// small fifo of frame byte counts
`timescale 1ns/1ps
module frame_count_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  output logic [W-1:0] head,
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] level;
  logic do_push;
  logic do_pop;
  // a push into a full fifo is dropped
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign empty = (level == '0);
  assign full = (level == (AW+1)'(DEPTH));
  assign head = mem[rd_ptr];
  // =======================================================
  // storage
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem[wr_ptr] <= push_data;
  end
  // pointers and fill level
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      level <= level + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : frame_count_fifo

// ===== testbench/serial_line_model.sv
// line-side model: presents status levels to the register bank
`timescale 1ns/1ps
module serial_line_model (
  input wire logic clk,
  input wire logic [7:0] st_req,
  input wire logic [7:0] sp_req,
  output logic [7:0] st,
  output logic [7:0] sp
);
  // =======================================================
  // status levels change just after a clock edge
  always_ff @(posedge clk)
  begin
    st <= st_req;
    sp <= sp_req;
  end
endmodule : serial_line_model

// ===== testbench/serial_ctrl_misc_status_regs_tb.sv
// self-checking bench for the channel register bank
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module serial_ctrl_misc_status_regs_tb;
  logic clk = 0, reset_n = 0, wr = 0, rd = 0, chan_b = 0, miss = 0, locked = 0, fdone = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, st_req = 8'h44, sp_req = 8'h06, rx = 8'h3C, ms = 8'h81;
  logic [7:0] rdata, st, sp, sync;
  logic [5:0] pend = 6'h2A;
  logic [2:0] vst = 3'h7;
  logic [13:0] fcnt = 14'h1234;
  logic irq, taken, lb, echo, dtr, bsrc, ben, rpin, rfm, mclk, fifo_en, feat;
  logic [15:0] tc;
  logic [1:0] rstate;
  int fail_count = 0;
  int check_count = 0;
  // =======================================================
  // clock and instances
  always #2.5 clk = ~clk;
  serial_line_model line (.clk(clk), .st_req(st_req), .sp_req(sp_req), .st(st), .sp(sp));
  serial_ctrl_misc_status_regs DUT (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IS_CHANNEL_B(chan_b), .BREAK_ABORT(st[7]),
    .TX_UNDERRUN(st[6]), .CTS(st[5]), .SYNC_HUNT(st[4]), .DCD(st[3]), .TX_EMPTY(st[2]),
    .ZERO_COUNT(st[1]), .RX_AVAIL(st[0]), .END_OF_FRAME(sp[7]), .CRC_ERROR(sp[6]),
    .RX_OVERRUN(sp[5]), .PARITY_ERROR(sp[4]), .RESIDUE(sp[3:1]), .ALL_SENT(sp[0]),
    .RX_DATA(rx), .MISC_STATUS(ms), .PENDING_IN(pend), .VECTOR_STATUS(vst),
    .FRAME_DONE(fdone), .FRAME_BYTE_COUNT(fcnt), .RECOVERY_LOCKED(locked),
    .MISSING_CLOCK_SEEN(miss), .IRQ(irq), .RX_DATA_TAKEN(taken), .LOCAL_LOOPBACK(lb),
    .AUTO_ECHO(echo), .DTR_SOURCE_BAUD_RATE_GENERATOR(dtr),
    .BAUD_RATE_GENERATOR_SOURCE(bsrc), .BAUD_RATE_GENERATOR_ENABLE(ben),
    .TIME_CONSTANT(tc), .RECOVERY_SOURCE_PIN(rpin), .RECOVERY_FM(rfm),
    .RECOVERY_STATE(rstate), .MISSING_CLOCK(mclk), .FIFO_ENABLE(fifo_en),
    .FEATURE_ACCESS(feat), .SYNC_PATTERN(sync));
  // =======================================================
  // bus tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wreg
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rchk
  // =======================================================
  // scenarios
  task automatic t_reset();
    rchk(4'hF, 8'hF0);
    rchk(4'h0, 8'h44);
    rchk(4'h1, 8'h06);
    tick(1);
    `CHK(rdata, 8'h00)
  endtask : t_reset
  task automatic t_misc();
    wreg(4'hE, 8'h15);
    `CHK({lb, echo, dtr, bsrc, ben}, 5'h15)
    wreg(4'hE, 8'h2A);
    `CHK({rstate, lb, echo, dtr, bsrc, ben}, 7'h2A)
    @(posedge clk) locked <= 1'b1;
    tick(2);
    `CHK(rstate, 2'h2)
    @(posedge clk) locked <= 1'b0;
    wreg(4'hE, 8'h60);
    `CHK(rstate, 2'h0)
    wreg(4'hE, 8'hA0);
    `CHK(rpin, 1'b1)
    wreg(4'hE, 8'h80);
    `CHK(rpin, 1'b0)
    wreg(4'hE, 8'hC0);
    `CHK(rfm, 1'b1)
    wreg(4'hE, 8'hE0);
    `CHK(rfm, 1'b0)
    @(posedge clk) miss <= 1'b1;
    @(posedge clk) miss <= 1'b0;
    wreg(4'hE, 8'h00);
    `CHK(mclk, 1'b1)
    wreg(4'hE, 8'h40);
    `CHK(mclk, 1'b0)
  endtask : t_misc
  task automatic t_irq();
    @(posedge clk) st_req <= 8'h64;
    tick(4);
    `CHK(irq, 1'b1)
    rchk(4'hB, 8'h20);
    wreg(4'hF, 8'h00);
    `CHK(irq, 1'b0)
    wreg(4'hB, 8'h20);
    wreg(4'hF, 8'h02);
    @(posedge clk) st_req <= 8'h66;
    tick(4);
    `CHK(irq, 1'b1)
    rchk(4'hB, 8'h02);
    wreg(4'hB, 8'h02);
    `CHK(irq, 1'b0)
  endtask : t_irq
  task automatic t_feat();
    wreg(4'h7, 8'hC3);
    `CHK(sync, 8'hC3)
    wreg(4'h3, 8'h5A);
    rchk(4'h9, 8'h00);
    rchk(4'h6, 8'h00);
    wreg(4'hF, 8'h05);
    `CHK({fifo_en, feat}, 2'h3)
    wreg(4'h7, 8'h40);
    rchk(4'h9, 8'h5A);
    `CHK(sync, 8'hC3)
    @(posedge clk) fdone <= 1'b1;
    @(posedge clk) fdone <= 1'b0;
    rchk(4'h6, 8'h34);
    rchk(4'h7, 8'h92);
  endtask : t_feat
  task automatic t_map();
    wreg(4'hC, 8'h34);
    wreg(4'hD, 8'h12);
    `CHK(tc, 16'h1234)
    rchk(4'hC, 8'h34);
    rchk(4'hD, 8'h12);
    // write then read with no gap between the strobes
    @(posedge clk) addr <= 4'hD;
    wdata <= 8'h56;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1;
    `CHK(rdata, 8'h56)
    wreg(4'h2, 8'hA5);
    rchk(4'h2, 8'hA5);
    rchk(4'h3, 8'h2A);
    @(posedge clk) chan_b <= 1'b1;
    rchk(4'h2, 8'hAF);
    rchk(4'h3, 8'h00);
    @(posedge clk) addr <= 4'h8;
    rd <= 1'b1;
    #1;
    `CHK(taken, 1'b1)
    @(posedge clk) rd <= 1'b0;
    #1;
    `CHK(rdata, 8'h3C)
    rchk(4'hA, 8'h81);
    rchk(4'hF, 8'h05);
    wreg(4'h0, 8'hFF);
    rchk(4'h0, 8'h66);
  endtask : t_map
  // =======================================================
  // verdict
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // main sequence after four reset cycles
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_misc();
    t_irq();
    t_feat();
    t_map();
    finish_test();
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule : serial_ctrl_misc_status_regs_tb
